// >>> design/uct_pkg.sv
// types shared by the serial transceiver
package uct_pkg;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } uct_bus_req_type;
    typedef struct packed {
        logic [2:0] char_size;
        logic [1:0] parity;
        logic two_stop;
    } uct_fmt_type;
    typedef enum logic [1:0] {
        UCT_TX_IDLE = 2'b01,
        UCT_TX_SEND = 2'b10
    } uct_tx_state_type;
endpackage

// >>> design/uct_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef UCT_REGS_SVH
`define UCT_REGS_SVH
`define UCT_ADDR_DATA 3'h0
`define UCT_ADDR_CSA 3'h1
`define UCT_ADDR_CSB 3'h2
`define UCT_ADDR_CSC_BDH 3'h3
`define UCT_ADDR_BDL 3'h4
`define UCT_CSA_TXC 6
`define UCT_CSA_BUF_EMPTY 5
`define UCT_CSA_FE 4
`define UCT_CSA_RXC 3
`define UCT_CSA_U2X 1
`define UCT_CSA_CKDIR 0
`define UCT_CSB_RXEN 4
`define UCT_CSB_TX_ENABLE_BIT 3
`define UCT_CSB_CS2 2
`define UCT_CSB_RXB8 1
`define UCT_CSB_TXB8 0
`define UCT_CSC_RSEL 7
`define UCT_CSC_SYNC 6
`define UCT_CSC_PM1 5
`define UCT_CSC_PM0 4
`define UCT_CSC_STOP 3
`define UCT_CSC_CS1 2
`define UCT_CSC_CS0 1
`define UCT_CSC_POL 0
`define UCT_CSC_RESET 8'h06
`define UCT_BYTE_ZERO 8'h00
`define UCT_BDH_ZERO 4'h0
`define UCT_NORMAL_LAST 4'hf
`define UCT_DOUBLE_LAST 4'h7
`define UCT_NORMAL_HALF 4'h7
`define UCT_DOUBLE_HALF 4'h3
`define UCT_CS_5 3'h0
`define UCT_CS_6 3'h1
`define UCT_CS_7 3'h2
`define UCT_CS_8 3'h3
`define UCT_CS_9 3'h7
`define UCT_FRAME_W 13
`endif

// >>> design/uct_top.sv
// serial transceiver: clocking, frame format, transmit path, basic receive
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "uct_regs.svh"
module uct_top #(
    parameter int BAUD_W = 12
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire uct_pkg::uct_bus_req_type bus_req,
    output logic [7:0] rd_data,
    output logic serial_out_o,
    output logic serial_out_oe,
    input wire logic serial_in_i,
    input wire logic xfer_clk_i,
    output logic xfer_clk_o,
    output logic xfer_clk_oe
);
    import uct_pkg::*;

    function automatic logic [3:0] data_bits(input logic [2:0] cs);
        // sizes 0-3 give five to eight bits, 7 gives nine, reserved codes act as eight
        case (cs)
            `UCT_CS_5: data_bits = 4'h5;
            `UCT_CS_6: data_bits = 4'h6;
            `UCT_CS_7: data_bits = 4'h7;
            `UCT_CS_8: data_bits = 4'h8;
            `UCT_CS_9: data_bits = 4'h9;
            default: data_bits = 4'h8;
        endcase
    endfunction

    function automatic logic [`UCT_FRAME_W-1:0] build_frame(input logic [8:0] d,
            input uct_fmt_type f);
        logic [3:0] n;
        logic p;
        n = data_bits(f.char_size);
        p = f.parity[0];
        build_frame = '1;
        build_frame[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                build_frame[i+1] = d[i];
                p = p ^ d[i];
            end
        end
        if (f.parity[1]) begin
            build_frame[n+4'h1] = p;
        end
    endfunction

    logic [7:0] csc_r, bdl_r, rx_data_r;
    logic [3:0] bdh_r;
    logic u2x_r, ckdir_r, tx_enable_bit_r, rxen_r, cs2_r, txb8_r, rxb8_r;
    logic txc_r, rxc_r, fe_r;
    logic [7:0] rd_data_r;
    uct_fmt_type fmt;
    logic sync_mode, pol, u2x_eff, master, slave;
    logic wr_data, wr_csa, wr_csb, wr_shared, wr_bdl, rd_data_acc;

    assign fmt = '{char_size: {cs2_r, csc_r[`UCT_CSC_CS1], csc_r[`UCT_CSC_CS0]},
        parity: {csc_r[`UCT_CSC_PM1], csc_r[`UCT_CSC_PM0]},
        two_stop: csc_r[`UCT_CSC_STOP]};
    assign sync_mode = csc_r[`UCT_CSC_SYNC];
    assign pol = csc_r[`UCT_CSC_POL];
    // double speed only counts in asynchronous mode
    assign u2x_eff = u2x_r & ~sync_mode;
    // direction bit picks internal or external clock
    assign master = sync_mode & ckdir_r;
    assign slave = sync_mode & ~ckdir_r;

    assign wr_data = bus_req.wr && bus_req.addr == `UCT_ADDR_DATA;
    assign wr_csa = bus_req.wr && bus_req.addr == `UCT_ADDR_CSA;
    assign wr_csb = bus_req.wr && bus_req.addr == `UCT_ADDR_CSB;
    assign wr_shared = bus_req.wr && bus_req.addr == `UCT_ADDR_CSC_BDH;
    assign wr_bdl = bus_req.wr && bus_req.addr == `UCT_ADDR_BDL;
    assign rd_data_acc = bus_req.rd && bus_req.addr == `UCT_ADDR_DATA;

    // control registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            csc_r <= `UCT_CSC_RESET;
            bdh_r <= `UCT_BDH_ZERO;
            bdl_r <= `UCT_BYTE_ZERO;
            u2x_r <= 1'b0;
            ckdir_r <= 1'b0;
            tx_enable_bit_r <= 1'b0;
            rxen_r <= 1'b0;
            cs2_r <= 1'b0;
            txb8_r <= 1'b0;
        end else begin
            if (wr_csa) begin
                u2x_r <= bus_req.wdata[`UCT_CSA_U2X];
                ckdir_r <= bus_req.wdata[`UCT_CSA_CKDIR];
            end
            if (wr_csb) begin
                tx_enable_bit_r <= bus_req.wdata[`UCT_CSB_TX_ENABLE_BIT];
                rxen_r <= bus_req.wdata[`UCT_CSB_RXEN];
                cs2_r <= bus_req.wdata[`UCT_CSB_CS2];
                txb8_r <= bus_req.wdata[`UCT_CSB_TXB8];
            end
            // select bit steers the shared location
            if (wr_shared && bus_req.wdata[`UCT_CSC_RSEL]) begin
                csc_r <= bus_req.wdata;
            end else if (wr_shared) begin
                bdh_r <= bus_req.wdata[3:0];
            end
            if (wr_bdl) begin
                bdl_r <= bus_req.wdata;
            end
        end
    end

    // baud generator
    logic [BAUD_W-1:0] baud_cnt_r;
    logic baud_tick;
    assign baud_tick = baud_cnt_r == '0;
    // reload on zero or on low byte write
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            baud_cnt_r <= '0;
        end else if (wr_bdl) begin
            baud_cnt_r <= BAUD_W'({bdh_r, bus_req.wdata});
        end else if (baud_tick) begin
            baud_cnt_r <= BAUD_W'({bdh_r, bdl_r});
        end else begin
            baud_cnt_r <= baud_cnt_r - 1'b1;
        end
    end

    // transfer clock: master toggle and slave synchroniser
    logic xck_r, xs1_r, xs2_r, xs3_r, s_rise, s_fall, m_rise, m_fall;
    logic ev_change, ev_sample, tx_step;
    logic [3:0] tx_pre_r;
    // two flops then edge detector on the third stage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            xs1_r <= 1'b0;
            xs2_r <= 1'b0;
            xs3_r <= 1'b0;
            xck_r <= 1'b0;
        end else begin
            xs1_r <= xfer_clk_i;
            xs2_r <= xs1_r;
            xs3_r <= xs2_r;
            xck_r <= master ? xck_r ^ baud_tick : 1'b0;
        end
    end
    // edge seen two clocks after the pin moved
    assign s_rise = slave & xs2_r & ~xs3_r;
    assign s_fall = slave & ~xs2_r & xs3_r;
    assign m_rise = master & baud_tick & ~xck_r;
    assign m_fall = master & baud_tick & xck_r;
    // change and sample on opposite edges
    // polarity picks which edge changes data
    assign ev_change = pol ? (s_fall | m_fall) : (s_rise | m_rise);
    assign ev_sample = pol ? (s_rise | m_rise) : (s_fall | m_fall);
    // pin driven as clock output only as master
    // enabled transmitter in master mode drives the clock pin
    assign xfer_clk_o = xck_r ^ pol;
    assign xfer_clk_oe = master & (tx_enable_bit_r | rxen_r);

    // prescale 16, or 8 in double speed
    always_ff @(posedge mclk) begin
        if (!rst_n || sync_mode) begin
            tx_pre_r <= 4'h0;
        end else if (baud_tick) begin
            tx_pre_r <= tx_step ? 4'h0 : tx_pre_r + 4'h1;
        end
    end
    assign tx_step = sync_mode ? ev_change :
        baud_tick && tx_pre_r == (u2x_eff ? `UCT_DOUBLE_LAST : `UCT_NORMAL_LAST);

    // transmitter
    uct_tx_state_type tx_state_r;
    logic [`UCT_FRAME_W-1:0] tx_sh_r;
    logic [3:0] tx_left_r;
    logic [8:0] tbuf_r;
    logic tbuf_full_r, tx_load, tx_done, tx_active_r;
    assign tx_done = tx_step && tx_state_r == UCT_TX_SEND && tx_left_r == 4'h1;
    // load when idle or right after the last stop bit
    assign tx_load = tx_step && tbuf_full_r && tx_enable_bit_r &&
        (tx_state_r == UCT_TX_IDLE || tx_left_r == 4'h1);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tbuf_r <= 9'h000;
            tbuf_full_r <= 1'b0;
        end else begin
            if (wr_data) begin
                tbuf_r <= {txb8_r, bus_req.wdata};
            end
            tbuf_full_r <= wr_data | (tbuf_full_r & ~tx_load);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_state_r <= UCT_TX_IDLE;
            tx_sh_r <= '1;
            tx_left_r <= 4'h0;
        end else begin
            case (tx_state_r)
                UCT_TX_IDLE: begin
                    if (tx_load) begin
                        // start, data lsb first, parity, stops
                        // parity built from the masked data
                        // bits above the char size never enter the frame
                        // ninth bit comes from the control bit
                        tx_sh_r <= build_frame(tbuf_r, fmt);
                        tx_left_r <= 4'h2 + data_bits(fmt.char_size) +
                            {3'h0, fmt.parity[1]} + {3'h0, fmt.two_stop};
                        tx_state_r <= UCT_TX_SEND;
                    end
                end
                UCT_TX_SEND: begin
                    // one bit per step until the frame is out
                    if (tx_load) begin
                        tx_sh_r <= build_frame(tbuf_r, fmt);
                        tx_left_r <= 4'h2 + data_bits(fmt.char_size) +
                            {3'h0, fmt.parity[1]} + {3'h0, fmt.two_stop};
                    end else if (tx_done) begin
                        tx_sh_r <= '1;
                        tx_left_r <= 4'h0;
                        tx_state_r <= UCT_TX_IDLE;
                    end else if (tx_step) begin
                        tx_sh_r <= {1'b1, tx_sh_r[`UCT_FRAME_W-1:1]};
                        tx_left_r <= tx_left_r - 4'h1;
                    end
                end
                default: begin
                    tx_state_r <= UCT_TX_IDLE;
                end
            endcase
        end
    end

    // pin ownership holds until pending data is gone
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_active_r <= 1'b0;
        end else begin
            tx_active_r <= tx_enable_bit_r | tbuf_full_r | (tx_state_r == UCT_TX_SEND);
        end
    end
    assign serial_out_o = tx_state_r == UCT_TX_SEND ? tx_sh_r[0] : 1'b1;
    // transmitter owns the pin while enabled
    assign serial_out_oe = tx_active_r;

    // receiver
    logic rs1_r, rxd;
    logic rx_busy_r, rx_samp;
    logic [3:0] rx_cnt_r, rx_idx_r, rx_n;
    logic [8:0] rx_sh_r;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rs1_r <= 1'b1;
            rxd <= 1'b1;
        end else begin
            rs1_r <= serial_in_i;
            rxd <= rs1_r;
        end
    end
    assign rx_n = data_bits(fmt.char_size);
    // sample count 16, or 8 in double speed
    assign rx_samp = sync_mode ? ev_sample : (baud_tick && rx_cnt_r == 4'h0);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rx_busy_r <= 1'b0;
            rx_cnt_r <= 4'h0;
            rx_idx_r <= 4'h0;
            rx_sh_r <= 9'h000;
        end else if (!rx_busy_r) begin
            rx_idx_r <= 4'h0;
            if (rxen_r && !rxd && (sync_mode ? ev_sample : baud_tick)) begin
                rx_busy_r <= 1'b1;
                // sync start is taken on its own sample edge, next sample is data
                rx_idx_r <= {3'h0, sync_mode};
                rx_cnt_r <= u2x_eff ? `UCT_DOUBLE_HALF : `UCT_NORMAL_HALF;
            end
        end else begin
            if (baud_tick) begin
                rx_cnt_r <= rx_cnt_r == 4'h0 ?
                    (u2x_eff ? `UCT_DOUBLE_LAST : `UCT_NORMAL_LAST) : rx_cnt_r - 4'h1;
            end
            if (rx_samp) begin
                rx_idx_r <= rx_idx_r + 4'h1;
                if (rx_idx_r == 4'h0 && rxd && !sync_mode) begin
                    rx_busy_r <= 1'b0;
                end else if (rx_idx_r >= 4'h1 && rx_idx_r <= rx_n) begin
                    rx_sh_r[rx_idx_r-4'h1] <= rxd;
                end else if (rx_idx_r == rx_n + 4'h1 + {3'h0, fmt.parity[1]}) begin
                    rx_busy_r <= 1'b0;
                end
            end
        end
    end

    // status flags: hardware set wins over clear
    logic rx_end;
    // receiver reads the same format as the transmitter
    // frame error from the first stop bit only
    assign rx_end = rx_busy_r && rx_samp &&
        rx_idx_r == rx_n + 4'h1 + {3'h0, fmt.parity[1]};
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            txc_r <= 1'b0;
            rxc_r <= 1'b0;
            fe_r <= 1'b0;
            rxb8_r <= 1'b0;
            rx_data_r <= `UCT_BYTE_ZERO;
        end else begin
            txc_r <= (tx_done & ~tx_load) |
                (txc_r & ~(wr_csa & bus_req.wdata[`UCT_CSA_TXC]));
            rxc_r <= rx_end | (rxc_r & ~rd_data_acc);
            if (rx_end) begin
                fe_r <= ~rxd;
                rx_data_r <= rx_sh_r[7:0] & ~(8'hff << rx_n);
                rxb8_r <= rx_sh_r[8];
            end
        end
    end

    // read port, data one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_data_r <= `UCT_BYTE_ZERO;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                `UCT_ADDR_DATA: rd_data_r <= rx_data_r;
                `UCT_ADDR_CSA: rd_data_r <= {1'b0, txc_r, ~tbuf_full_r, fe_r, rxc_r,
                    1'b0, u2x_r, ckdir_r};
                `UCT_ADDR_CSB: rd_data_r <= {3'h0, rxen_r, tx_enable_bit_r, cs2_r, rxb8_r, txb8_r};
                `UCT_ADDR_CSC_BDH: rd_data_r <= csc_r;
                `UCT_ADDR_BDL: rd_data_r <= bdl_r;
                default: rd_data_r <= `UCT_BYTE_ZERO;
            endcase
        end else begin
            rd_data_r <= `UCT_BYTE_ZERO;
        end
    end
    assign rd_data = rd_data_r;

    chk_slave_latency: assert property (@(posedge mclk) disable iff (!rst_n)
        s_rise |-> $past(xfer_clk_i, 2) && !$past(xfer_clk_i, 3))
        else $error("slave edge latency wrong");
    chk_idle_high: assert property (@(posedge mclk) disable iff (!rst_n)
        tx_state_r == UCT_TX_IDLE |-> serial_out_o)
        else $error("idle line not high");
    chk_start_low: assert property (@(posedge mclk) disable iff (!rst_n)
        tx_state_r == UCT_TX_IDLE && tx_load |=> !serial_out_o)
        else $error("start bit not low");
    chk_edge_opposite: assert property (@(posedge mclk) disable iff (!rst_n)
        !(ev_change && ev_sample))
        else $error("change and sample on one edge");
    chk_shared_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_shared && !bus_req.wdata[`UCT_CSC_RSEL] |=> $stable(csc_r))
        else $error("control C written without select");
    chk_baud_reload: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_bdl |=> baud_cnt_r == BAUD_W'({bdh_r, bdl_r}))
        else $error("divisor low write did not reload");
    chk_double_step: assert property (@(posedge mclk) disable iff (!rst_n)
        tx_step && !sync_mode && u2x_r |-> tx_pre_r == `UCT_DOUBLE_LAST)
        else $error("double speed divide wrong");
    chk_master_clk: assert property (@(posedge mclk) disable iff (!rst_n)
        xfer_clk_oe |-> sync_mode && ckdir_r)
        else $error("clock pin driven outside master");
    chk_buf_load: assert property (@(posedge mclk) disable iff (!rst_n)
        tx_load && !wr_data |=> !tbuf_full_r)
        else $error("buffer not emptied on load");
    chk_pin_owned: assert property (@(posedge mclk) disable iff (!rst_n)
        tx_enable_bit_r |=> serial_out_oe)
        else $error("enabled transmitter not on pin");
    chk_sync_change: assert property (@(posedge mclk) disable iff (!rst_n)
        sync_mode && $changed(serial_out_o) |-> $past(ev_change))
        else $error("sync data changed off the change edge");
    cov_back_to_back: cover property (@(posedge mclk) disable iff (!rst_n)
        tx_load && tx_state_r == UCT_TX_SEND);
    cov_sync_slave: cover property (@(posedge mclk) disable iff (!rst_n) s_fall);
    cov_frame_error: cover property (@(posedge mclk) disable iff (!rst_n) rx_end && !rxd);
endmodule
`default_nettype wire

// >>> verif/uct_remote_node.sv
// remote serial node: frame decoder on the tx line, loopback on the rx line
`timescale 1ns/100ps
`default_nettype none
module uct_remote_node (
    input wire logic mclk,
    input wire logic serial_out_o,
    input wire logic serial_out_oe,
    output logic serial_in_i,
    output logic xfer_clk_i,
    input wire logic [15:0] bit_cycles,
    input wire logic [3:0] nbits,
    input wire logic par_en,
    input wire logic two_stop,
    input wire logic slv_clk_en,
    output logic [8:0] got_data,
    output logic got_start,
    output logic got_par,
    output logic [1:0] got_stop,
    output logic [7:0] frame_cnt
);
    // a released tx line floats high through its pull-up
    assign serial_in_i = (serial_out_oe === 1'b1) ? serial_out_o : 1'b1;
    // slave clock period is 16 system clocks, well under a quarter rate
    logic [2:0] half_cnt = 3'h0;
    always @(posedge mclk) begin
        half_cnt <= slv_clk_en ? half_cnt + 3'h1 : 3'h0;
        if (slv_clk_en && half_cnt == 3'h7) begin
            xfer_clk_i <= ~xfer_clk_i;
        end
    end
    initial begin
        xfer_clk_i = 1'b0;
        frame_cnt = 8'h00;
        got_data = 9'h000;
        got_start = 1'b1;
        got_par = 1'b0;
        got_stop = 2'h0;
        forever begin
            @(posedge mclk);
            if (serial_out_oe === 1'b1 && serial_out_o === 1'b0) begin
                // start found, then sample each bit at its middle
                repeat (bit_cycles / 2) @(posedge mclk);
                got_start = serial_out_o;
                got_data = 9'h000;
                for (int i = 0; i < nbits; i++) begin
                    repeat (bit_cycles) @(posedge mclk);
                    got_data[i] = serial_out_o;
                end
                got_par = 1'b0;
                if (par_en) begin
                    repeat (bit_cycles) @(posedge mclk);
                    got_par = serial_out_o;
                end
                repeat (bit_cycles) @(posedge mclk);
                got_stop = {1'b1, serial_out_o};
                if (two_stop) begin
                    repeat (bit_cycles) @(posedge mclk);
                    got_stop[1] = serial_out_o;
                end
                frame_cnt = frame_cnt + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/usart_clocking_framing_tx_tb_top.sv
// testbench: register access, all frame formats, rates and sync clock
`timescale 1ns/100ps
`default_nettype none
module usart_clocking_framing_tx_tb_top;
    import uct_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    uct_bus_req_type bus_req = '0;
    logic [7:0] rd_data;
    logic serial_out_o, serial_out_oe, serial_in_i, xfer_clk_i, xfer_clk_o, xfer_clk_oe;
    logic [15:0] bit_cycles = 16'h0020;
    logic [3:0] nbits = 4'h8;
    logic par_en = 1'b0;
    logic two_stop = 1'b0;
    logic slv_clk_en = 1'b0;
    logic [8:0] got_data;
    logic got_start, got_par;
    logic [1:0] got_stop;
    logic [7:0] frame_cnt;
    int err_count = 0;
    int checks = 0;
    logic [31:0] lfsr_r = 32'h40d3578a;
    logic [2:0] cs_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    always #4 mclk = ~mclk;
    uct_top #(.BAUD_W(12)) DUT (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req),
        .rd_data(rd_data), .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe),
        .serial_in_i(serial_in_i), .xfer_clk_i(xfer_clk_i), .xfer_clk_o(xfer_clk_o),
        .xfer_clk_oe(xfer_clk_oe));
    uct_remote_node far_node (.mclk(mclk), .serial_out_o(serial_out_o),
        .serial_out_oe(serial_out_oe), .serial_in_i(serial_in_i), .xfer_clk_i(xfer_clk_i),
        .bit_cycles(bit_cycles), .nbits(nbits), .par_en(par_en), .two_stop(two_stop),
        .slv_clk_en(slv_clk_en),
        .got_data(got_data), .got_start(got_start), .got_par(got_par),
        .got_stop(got_stop), .frame_cnt(frame_cnt));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction
    function automatic logic exp_par(input logic [8:0] d, input logic [1:0] p);
        return p[1] & (^d ^ p[0]);
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask
    task automatic wait_frames(input logic [7:0] n);
        int k;
        k = 0;
        while (frame_cnt !== n && k < 4000) begin
            @(posedge mclk);
            k++;
        end
        chk("frame count", {1'b0, n}, {1'b0, frame_cnt});
    endtask
    task automatic run_fmt(input logic [2:0] cs, input logic [1:0] p, input logic st,
        input logic u2x, input logic sm, input logic pol);
        logic [8:0] w [2];
        logic [8:0] m;
        logic [7:0] d, c0;
        int nb, k;
        nb = (cs == 3'h7) ? 9 : cs + 5;
        m = 9'h1ff >> (9 - nb);
        bit_cycles = (u2x || sm) ? 16'h0010 : 16'h0020;
        slv_clk_en = sm;
        nbits = nb[3:0];
        par_en = p[1];
        two_stop = st;
        // clear tx complete before loading data
        bus_wr(3'h1, {1'b0, 1'b1, 4'h0, u2x, 1'b0});
        bus_wr(3'h3, {1'b1, sm, p, st, cs[1:0], pol});
        c0 = frame_cnt;
        for (int i = 0; i < 2; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            w[i] = lfsr_r[8:0];
            bus_wr(3'h2, {3'h0, 2'h3, cs[2], 1'b0, w[i][8]});
            bus_wr(3'h0, w[i][7:0]);
            k = 0;
            d = 8'h00;
            while (i == 0 && d[5] !== 1'b1 && k < 100) begin
                bus_rd(3'h1, d);
                k++;
            end
        end
        for (int j = 0; j < 2; j++) begin
            wait_frames(c0 + 8'(j + 1));
            chk("start bit", 9'h000, {8'h00, got_start});
            chk("data bits", w[j] & m, got_data);
            chk("parity bit", {8'h00, exp_par(w[j] & m, p)}, {8'h00, got_par});
            chk("stop bits", 9'h003, {7'h00, got_stop});
        end
        repeat (bit_cycles) @(posedge mclk);
        chk("idle line", 9'h001, {8'h00, serial_out_o});
        bus_rd(3'h1, d);
        chk("tx done flags", 9'h003, {7'h00, d[6:5]});
        chk("rx flags", 9'h001, {7'h00, d[4:3]});
        bus_rd(3'h0, d);
        chk("loopback data", {1'b0, w[1][7:0] & m[7:0]}, {1'b0, d});
    endtask
    initial begin
        logic [7:0] d;
        int t;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        bus_rd(3'h3, d);
        chk("control c reset", 9'h006, {1'b0, d});
        bus_wr(3'h3, 8'h00);
        bus_wr(3'h4, 8'h01);
        bus_rd(3'h3, d);
        chk("shared location", 9'h006, {1'b0, d});
        bus_wr(3'h5, 8'hff);
        bus_rd(3'h5, d);
        chk("unmapped read", 9'h000, {1'b0, d});
        chk("tx pin released", 9'h000, {8'h00, serial_out_oe});
        bus_wr(3'h2, 8'h18);
        repeat (2) @(posedge mclk);
        chk("tx pin owned", 9'h001, {8'h00, serial_out_oe});
        chk("idle high", 9'h001, {8'h00, serial_out_o});
        for (int a = 0; a < 5; a++) begin
            for (int p = 0; p < 4; p++) begin
                for (int s = 0; s < 4; s++) begin
                    if (p != 1) begin
                        run_fmt(cs_tab[a], 2'(p), s[0], s[1], 1'b0, 1'b0);
                    end
                end
            end
        end
        for (int s = 0; s < 4; s++) begin
            run_fmt(cs_tab[s], 2'h2 + 2'(s[0]), s[1], s[0], 1'b1, s[1]);
        end
        slv_clk_en = 1'b0;
        for (int u = 0; u < 2; u++) begin
            bus_wr(3'h1, {6'h00, u[0], 1'b1});
            bus_wr(3'h3, 8'hc6);
            repeat (4) @(posedge mclk);
            chk("sync clock oe", 9'h001, {8'h00, xfer_clk_oe});
            t = 0;
            #1;
            d[0] = xfer_clk_o;
            repeat (40) begin
                @(posedge mclk);
                #1;
                t = t + ((xfer_clk_o !== d[0]) ? 1 : 0);
                d[0] = xfer_clk_o;
            end
            chk("sync clock rate", 9'h001, {8'h00, t >= 19 && t <= 21});
        end
        bus_wr(3'h1, 8'h00);
        bus_wr(3'h3, 8'h86);
        repeat (4) @(posedge mclk);
        chk("async clock oe", 9'h000, {8'h00, xfer_clk_oe});
        end_of_test();
    end
    initial begin
        #800000;
        err_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
